// file: hdl/mac_accumulator_overflow.sv
// Purpose: multiply-accumulate datapath with wrap-around and overflow pulse
// Assumes: narrow operands sit in the low bits, upper bits ignored; all sources from the core_clk domain
// Notes:   wrap modulo accumulator width; one-cycle overflow pulse per event
//          reset wins over enable in every register
//
// Functional notes
// - The multiplier takes signed or unsigned operands at 9, 18 or 36 bits.
// - On overflow the accumulator wraps without saturating and flags overflow.
// - Unsigned overflow is a new sum numerically smaller than the old one.
// - Signed overflow is two positives giving negative or two negatives positive.
// - The overflow output is a single-cycle pulse per event.
// - Every input, pipeline and output register picks enable and reset of four.
`include "mac_map.svh"
module mac_accumulator_overflow #(
  parameter int unsigned OPW  = `MAC_OPW,
  parameter int unsigned ACCW = `MAC_ACCW
) (
  // clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  rst_b,
  // operands
  input  wire logic [OPW-1:0]        op_a,
  input  wire logic [OPW-1:0]        op_b,
  input  wire mac_pkg::mac_width_t   width_sel,
  input  wire logic                  signed_mode,
  // shared control sources
  input  wire logic                  clock_enable_sel_0,
  input  wire logic                  clock_enable_sel_1,
  input  wire logic                  clock_enable_sel_2,
  input  wire logic                  clock_enable_sel_3,
  input  wire logic                  reset_sel_0,
  input  wire logic                  reset_sel_1,
  input  wire logic                  reset_sel_2,
  input  wire logic                  reset_sel_3,
  // per-register picks, index by register number
  input  wire logic [`MAC_NREG*`MAC_SELW-1:0] ce_pick,
  input  wire logic [`MAC_NREG*`MAC_SELW-1:0] rst_pick,
  // results
  output logic [ACCW-1:0]            acc_out,
  output logic                       overflow
);
  localparam int unsigned PW = 2 * OPW;

  wire logic [`MAC_NSRC-1:0] ce_src;
  wire logic [`MAC_NSRC-1:0] rst_src;
  // one enable and one clear per register, global reset folded in
  wire logic [`MAC_NREG-1:0] ce;
  wire logic [`MAC_NREG-1:0] clr;
  assign ce_src  = {clock_enable_sel_3, clock_enable_sel_2,
                    clock_enable_sel_1, clock_enable_sel_0};
  assign rst_src = {reset_sel_3, reset_sel_2, reset_sel_1, reset_sel_0};

  // two-bit field of the packed pick word for one register
  function automatic logic [`MAC_SELW-1:0] pick_of(input logic [`MAC_NREG*`MAC_SELW-1:0] v,
                                                   input int unsigned idx);
    return v[idx*`MAC_SELW +: `MAC_SELW];
  endfunction

  // picks split out by register number
  wire logic [`MAC_SELW-1:0] ce_pick_in_a;
  wire logic [`MAC_SELW-1:0] ce_pick_in_b;
  wire logic [`MAC_SELW-1:0] ce_pick_pipe;
  wire logic [`MAC_SELW-1:0] ce_pick_out;
  wire logic [`MAC_SELW-1:0] rst_pick_in_a;
  wire logic [`MAC_SELW-1:0] rst_pick_in_b;
  wire logic [`MAC_SELW-1:0] rst_pick_pipe;
  wire logic [`MAC_SELW-1:0] rst_pick_out;

  assign ce_pick_in_a  = pick_of(ce_pick, `MAC_R_IN_A);
  assign ce_pick_in_b  = pick_of(ce_pick, `MAC_R_IN_B);
  assign ce_pick_pipe  = pick_of(ce_pick, `MAC_R_PIPE);
  assign ce_pick_out   = pick_of(ce_pick, `MAC_R_OUT);
  assign rst_pick_in_a = pick_of(rst_pick, `MAC_R_IN_A);
  assign rst_pick_in_b = pick_of(rst_pick, `MAC_R_IN_B);
  assign rst_pick_pipe = pick_of(rst_pick, `MAC_R_PIPE);
  assign rst_pick_out  = pick_of(rst_pick, `MAC_R_OUT);

  // input A register controls
  mac_ctl_sel u_sel_in_a (
    .rst_b     (rst_b),
    .ce_pick   (ce_pick_in_a),
    .rst_pick  (rst_pick_in_a),
    .ce_src    (ce_src),
    .rst_src   (rst_src),
    .stage_ce  (ce[`MAC_R_IN_A]),
    .stage_rst (clr[`MAC_R_IN_A])
  );

  // input B register controls, also width and sign
  mac_ctl_sel u_sel_in_b (
    .rst_b     (rst_b),
    .ce_pick   (ce_pick_in_b),
    .rst_pick  (rst_pick_in_b),
    .ce_src    (ce_src),
    .rst_src   (rst_src),
    .stage_ce  (ce[`MAC_R_IN_B]),
    .stage_rst (clr[`MAC_R_IN_B])
  );

  // pipeline register controls
  mac_ctl_sel u_sel_pipe (
    .rst_b     (rst_b),
    .ce_pick   (ce_pick_pipe),
    .rst_pick  (rst_pick_pipe),
    .ce_src    (ce_src),
    .rst_src   (rst_src),
    .stage_ce  (ce[`MAC_R_PIPE]),
    .stage_rst (clr[`MAC_R_PIPE])
  );

  // output register controls
  mac_ctl_sel u_sel_out (
    .rst_b     (rst_b),
    .ce_pick   (ce_pick_out),
    .rst_pick  (rst_pick_out),
    .ce_src    (ce_src),
    .rst_src   (rst_src),
    .stage_ce  (ce[`MAC_R_OUT]),
    .stage_rst (clr[`MAC_R_OUT])
  );

  // extend an operand from the chosen native width to the full width
  function automatic logic [PW-1:0] widen(input logic [OPW-1:0] v,
                                          input mac_pkg::mac_width_t w,
                                          input logic sgn);
    logic [PW-1:0] r;
    r = '0;
    unique case (w)
      mac_pkg::MAC_WIDTH_9:  r = {{(PW-`MAC_W9){sgn & v[`MAC_W9-1]}}, v[`MAC_W9-1:0]};
      mac_pkg::MAC_WIDTH_18: r = {{(PW-`MAC_W18){sgn & v[`MAC_W18-1]}}, v[`MAC_W18-1:0]};
      mac_pkg::MAC_WIDTH_36: r = {{(PW-`MAC_W36){sgn & v[`MAC_W36-1]}}, v[`MAC_W36-1:0]};
      default:               r = '0;
    endcase
    return r;
  endfunction

  // input registers
  logic [OPW-1:0]       reg_a;
  logic [OPW-1:0]       reg_b;
  mac_pkg::mac_width_t  reg_w;
  logic                 reg_sgn;
  always_ff @(posedge core_clk) begin
    if (clr[`MAC_R_IN_A]) begin
      reg_a <= '0;
    end else if (ce[`MAC_R_IN_A]) begin
      reg_a <= op_a;
    end
  end

  // width and sign ride with operand B into the product
  always_ff @(posedge core_clk) begin
    if (clr[`MAC_R_IN_B]) begin
      reg_b   <= '0;
      reg_w   <= mac_pkg::MAC_WIDTH_9;
      reg_sgn <= 1'b0;
    end else if (ce[`MAC_R_IN_B]) begin
      reg_b   <= op_b;
      reg_w   <= width_sel;
      reg_sgn <= signed_mode;
    end
  end

  // multiply over the doubled width; the low PW bits are exact either way
  wire logic [PW-1:0] ext_a;
  wire logic [PW-1:0] ext_b;
  wire logic [PW-1:0] next_prod;
  assign ext_a     = widen(reg_a, reg_w, reg_sgn);
  assign ext_b     = widen(reg_b, reg_w, reg_sgn);
  assign next_prod = PW'(ext_a * ext_b);

  // pipeline register; the sign travels with the product so a mode
  // change mid-stream never mislabels data in flight
  logic [PW-1:0] prod;
  logic          prod_sgn;
  always_ff @(posedge core_clk) begin
    if (clr[`MAC_R_PIPE]) begin
      prod     <= '0;
      prod_sgn <= 1'b0;
    end else if (ce[`MAC_R_PIPE]) begin
      prod     <= next_prod;
      prod_sgn <= reg_sgn;
    end
  end

  // accumulate, wrapping modulo 2**ACCW
  wire logic [ACCW-1:0] addend;
  wire logic [ACCW-1:0] next_acc;
  wire logic            unsigned_ovf;
  wire logic            signed_ovf;
  wire logic            next_ovf;
  // keep the low ACCW bits of the product, signed or unsigned alike; the sign fill is cut off
  assign addend   = ACCW'({{ACCW{prod_sgn & prod[PW-1]}}, prod});
  assign next_acc = acc_out + addend;
  assign unsigned_ovf = next_acc < acc_out;
  assign signed_ovf   = (acc_out[ACCW-1] == addend[ACCW-1]) &&
                        (next_acc[ACCW-1] != acc_out[ACCW-1]);
  // overflow kind follows the product, not the live mode pin
  assign next_ovf = prod_sgn ? signed_ovf : unsigned_ovf;

  // output register; fabric counts overflow pulses for wider sums
  always_ff @(posedge core_clk) begin
    if (clr[`MAC_R_OUT]) begin
      acc_out <= '0;
    end else if (ce[`MAC_R_OUT]) begin
      acc_out <= next_acc;
    end
  end

  // pulse only on a loading edge, so a stalled stage never repeats it
  always_ff @(posedge core_clk) begin
    if (clr[`MAC_R_OUT]) begin
      overflow <= 1'b0;
    end else if (ce[`MAC_R_OUT]) begin
      overflow <= next_ovf;
    end else begin
      overflow <= 1'b0;
    end
  end
endmodule

// file: hdl/mac_map.svh
// Purpose: constants for the multiply-accumulate datapath
// Assumes: one clock, synchronous active-low reset
// Notes:   definitions only
`ifndef MAC_MAP_SVH
`define MAC_MAP_SVH
`define MAC_W9       9
`define MAC_W18      18
`define MAC_W36      36
`define MAC_OPW      36
`define MAC_ACCW     52
`define MAC_NSRC     4
`define MAC_SELW     2
`define MAC_NREG     4
`define MAC_R_IN_A   0
`define MAC_R_IN_B   1
`define MAC_R_PIPE   2
`define MAC_R_OUT    3
`endif

// file: hdl/mac_pkg.sv
// Purpose: types for the multiply-accumulate datapath
// Assumes: included constants header
// Notes:   width selection codes
package mac_pkg;
  typedef enum logic [1:0] {
    MAC_WIDTH_9  = 2'h0,
    MAC_WIDTH_18 = 2'h1,
    MAC_WIDTH_36 = 2'h2
  } mac_width_t;
endpackage

// file: hdl/mac_ctl_sel.sv
// Purpose: picks one clock enable and one reset out of four shared sources
// Assumes: reset sources active high, enables active high
// Notes:   combinational, so a stage acts on its pick at that same edge
`include "mac_map.svh"
module mac_ctl_sel (
  // global reset
  input  wire logic                  rst_b,
  // selections and sources
  input  wire logic [`MAC_SELW-1:0]  ce_pick,
  input  wire logic [`MAC_SELW-1:0]  rst_pick,
  input  wire logic [`MAC_NSRC-1:0]  ce_src,
  input  wire logic [`MAC_NSRC-1:0]  rst_src,
  // chosen controls
  output logic                       stage_ce,
  output logic                       stage_rst
);
  wire logic ce_mux;
  wire logic rst_mux;
  assign ce_mux  = ce_src[ce_pick];
  assign rst_mux = rst_src[rst_pick];
  always_comb begin
    stage_ce  = ce_mux;
    stage_rst = rst_mux | ~rst_b;
  end
endmodule

// file: test/mac_acc_monitor.sv
// Purpose: port checks for the mac datapath
// Assumes: one clock, sync active-low reset
// Notes:   bound below
module mac_acc_monitor #(parameter int unsigned ACCW = 52) (
  input wire logic core_clk, rst_b, signed_mode, overflow, reset_sel_0, reset_sel_1,
  input wire logic clock_enable_sel_0, clock_enable_sel_1, clock_enable_sel_2,
  input wire logic clock_enable_sel_3, reset_sel_2, reset_sel_3,
  input wire logic [7:0] ce_pick, rst_pick,
  input wire logic [ACCW-1:0] acc_out);
  timeunit 1ns;
  timeprecision 1ns;
  wire [3:0] ces = {clock_enable_sel_3, clock_enable_sel_2, clock_enable_sel_1, clock_enable_sel_0};
  wire [3:0] rss = {reset_sel_3, reset_sel_2, reset_sel_1, reset_sel_0};
  wire ce_o = ces[ce_pick[7:6]];
  wire rs_o = rss[rst_pick[7:6]];
  logic [ACCW-1:0] prev;
  logic [2:0] run;
  logic sm_q;
  wire [ACCW-1:0] dlt = acc_out - prev;
  wire go = run == 3'h7 && signed_mode == sm_q;
  // mode judged only once the pipe holds nothing from an older mode
  always_ff @(posedge core_clk) begin
    prev <= acc_out;
    sm_q <= signed_mode;
    run <= (!rst_b || !(&ces) || |rss || signed_mode != sm_q) ? 3'h0 : run + {2'h0, !go};
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  sequence s_idle; (!ce_o && !rs_o) [*2]; endsequence
  sequence s_clr; rs_o [*2]; endsequence
  AST_RST: assert property (disable iff (1'b0) !rst_b |=> acc_out == '0 && !overflow)
    else $error("reset");
  AST_CLR: assert property (s_clr |=> acc_out == '0 && !overflow)
    else $error("picked reset");
  AST_HOLD: assert property (s_idle |=> $stable(acc_out) && !overflow)
    else $error("hold");
  AST_PULSE: assert property (overflow |-> acc_out != prev)
    else $error("pulse");
  AST_UNS: assert property (go && !signed_mode |-> overflow == (acc_out < prev))
    else $error("unsigned");
  AST_WRAP: assert property (go && overflow && !signed_mode |-> acc_out != '1)
    else $error("saturated");
  AST_SGN: assert property (go && signed_mode |-> overflow ==
    (prev[ACCW-1] == dlt[ACCW-1] && acc_out[ACCW-1] != prev[ACCW-1])) else $error("signed");
endmodule
bind mac_accumulator_overflow mac_acc_monitor #(.ACCW(ACCW)) u_mon (.*);

// file: test/mac_fabric_model.sv
// Purpose: fabric side: pads operand A, counts overflow pulses
// Assumes: core_clk domain
// Notes:   count forms the extended upper bits
module mac_fabric_model (
  input wire logic core_clk, rst_b, overflow, signed_mode,
  input wire mac_pkg::mac_width_t width_sel,
  input wire logic [35:0] raw,
  output logic [35:0] op,
  output logic [7:0] ext_hi);
  timeunit 1ns;
  timeprecision 1ns;
  wire [5:0] nb = width_sel == mac_pkg::MAC_WIDTH_9 ? 6'h9 :
                  width_sel == mac_pkg::MAC_WIDTH_18 ? 6'h12 : 6'h24;
  wire [35:0] msk = (36'h1 << nb) - 36'h1;
  assign op = (raw & msk) | ((signed_mode & raw[nb-6'h1]) ? ~msk : '0);
  always_ff @(posedge core_clk) ext_hi <= !rst_b ? 8'h0 : ext_hi + {7'h0, overflow};
endmodule

// file: test/testbench.sv
// Purpose: self-checking bench for the mac datapath
// Assumes: inputs change on the falling edge
// Notes:   fabric model pads operand A
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 0, rst_b = 0, signed_mode = 0, overflow;
  logic clock_enable_sel_0, clock_enable_sel_1, clock_enable_sel_2, clock_enable_sel_3;
  logic reset_sel_0, reset_sel_1, reset_sel_2, reset_sel_3;
  logic [35:0] raw = '0, op_a, op_b = '0;
  logic [7:0] ce_pick = '0, rst_pick = '0, ext_hi;
  logic [51:0] acc_out, exp_acc;
  mac_pkg::mac_width_t width_sel = mac_pkg::MAC_WIDTH_36;
  int num_errors = 0, n_tests = 0;
  always #25 core_clk = ~core_clk;
  mac_accumulator_overflow DUT (.*);
  mac_fabric_model u_fab (.core_clk, .rst_b, .overflow, .signed_mode, .width_sel, .raw,
                          .op(op_a), .ext_hi);
  task automatic chk(logic [51:0] got, logic [51:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic srcs(logic [3:0] c, logic [3:0] r);
    {clock_enable_sel_3, clock_enable_sel_2, clock_enable_sel_1, clock_enable_sel_0} = c;
    {reset_sel_3, reset_sel_2, reset_sel_1, reset_sel_0} = r;
  endtask
  task automatic op(logic [35:0] a, logic [35:0] b, int n);
    raw = a;
    op_b = b;
    repeat (n) @(negedge core_clk);
  endtask
  task automatic t_widths;
    for (int s = 0; s < 2; s++) begin
      rst_b = 0;
      signed_mode = s[0];
      exp_acc = '0;
      op('0, '0, 6);
      rst_b = 1;
      for (int w = 0; w < 3; w++) begin
        width_sel = mac_pkg::mac_width_t'(w);
        op(36'hF_FFFF_FFFF, 36'h3, 1);
        exp_acc = s ? exp_acc - 52'h3 : exp_acc + 52'h3 * ((52'h1 << (9 << w)) - 52'h1);
      end
      op('0, '0, 9);
      chk(acc_out, exp_acc);
    end
  endtask
  task automatic t_ovf;
    rst_b = 0;
    signed_mode = 1;
    op('0, '0, 6);
    rst_b = 1;
    op('0, '0, 8);
    op(36'h200_0000, 36'h200_0000, 2);
    op(36'hF_FE00_0000, 36'h200_0000, 1);
    op('0, '0, 4);
    signed_mode = 0;
    op('0, '0, 8);
    chk(acc_out, 52'h4_0000_0000_0000);
    op(36'h600_0000, 36'h200_0000, 1);
    op('0, '0, 4);
    chk(acc_out, '0);
    chk(52'(ext_hi), 52'h3);
  endtask
  task automatic t_sel;
    ce_pick = 8'hE4;
    rst_pick = 8'h1B;
    op(36'h5, 36'h3, 1);
    op('0, '0, 4);
    chk(acc_out, 52'hF);
    srcs(4'h7, 4'h0);
    op(36'h5, 36'h3, 1);
    op('0, '0, 4);
    chk(acc_out, 52'hF);
    srcs(4'hF, 4'h1);
    op('0, '0, 3);
    chk(acc_out, '0);
    srcs(4'hE, 4'h0);
    op(36'h5, 36'h3, 1);
    op('0, '0, 4);
    chk(acc_out, '0);
    srcs(4'hF, 4'h8);
    op(36'h5, 36'h3, 2);
    op('0, '0, 4);
    chk(acc_out, '0);
    srcs(4'hF, 4'h0);
    op(36'h5, 36'h3, 1);
    op('0, '0, 4);
    chk(acc_out, 52'hF);
  endtask
  task automatic conclude;
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    srcs(4'hF, 4'h0);
    t_widths;
    t_ovf;
    t_sel;
    conclude;
  end
  initial begin
    repeat (2000) @(posedge core_clk);
    num_errors++;
    conclude;
  end
endmodule
